// >>> shared/flash_burst_consts.vh
// constants shared by the synchronous burst read port and its word memory
`ifndef FLASH_BURST_CONSTS_VH
`define FLASH_BURST_CONSTS_VH

// ****************************************************************
// apb register byte offsets
// ****************************************************************
`define REG_CONFIG    8'h00
`define REG_STATUS    8'h04
`define REG_MEM_ADDR  8'h08
`define REG_MEM_DATA  8'h0C
`define REG_CTRL      8'h10

// ****************************************************************
// burst configuration field positions and reset value
// ****************************************************************
`define CFG_READ_SEL  15
`define CFG_XLAT_HI   14
`define CFG_XLAT_LO   11
`define CFG_YLAT      9
`define CFG_RDY_TIME  8
`define CFG_ORDER     7
`define CFG_EDGE      6
`define CFG_LEN_HI    2
`define CFG_LEN_LO    0
`define CFG_RESET     16'h8000
`define CTRL_SLOW     0
`define CTRL_RESET    1'b0

// ****************************************************************
// burst length codes and array shape
// ****************************************************************
`define LEN_4         3'b001
`define LEN_8         3'b010
`define LEN_CONT      3'b111
`define ADDR_W        8
`define DATA_W        16
`define MEM_DEPTH     256

`endif

// >>> verilog/burst_word_mem.v
// word array behind the burst port, registered read data
`timescale 1ns/1ns
`default_nettype none
`include "flash_burst_consts.vh"

module burst_word_mem (
  // clock
  input  wire                 pclk,
  // write side
  input  wire                 wr_en,
  input  wire [`ADDR_W-1:0]   wr_addr,
  input  wire [`DATA_W-1:0]   wr_data,
  // read side
  input  wire [`ADDR_W-1:0]   rd_addr,
  output reg  [`DATA_W-1:0]   rd_data
);

  reg [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];

  // single write port, read data always from a flop
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // burst_word_mem

`default_nettype wire

// >>> verilog/sync_burst_read_port.v
// synchronous burst read port of a flash array, configured over apb
//
// Overview of operation
// - start address captured at first active edge with latch low, or latch rising.
// - first word presented only after the initial latency from capture.
// - data pins driven only while output enable is low.
// - burst counter advances on active edges per advance input and inter-word latency.
// - continuous length code reads whole array sequentially, wrapping at the end.
// - continuous mode needs advance low; advance high suspends the burst.
// - unaligned continuous start pulls ready low for an extra wait state.
// - new latch pulse mid-burst restarts with data after the initial latency.
// - pipelined burst always shows at least one invalid data period.
// - output enable and advance both high suspend; counter frozen, pins released.
// - output enable low resumes; address advances only while advance low.
// - control inputs sampled on the configured active clock edge.
// - slow clock with latency two ignores advance on odd cycles.
// - burst operations only while read select chooses synchronous reads.
// - clock edge bit zero selects falling edge, one selects rising edge.
// - inter-word latency one changes data each cycle, two every second cycle.
// - ready timing bit zero lows ready at invalid edge, one a cycle earlier.
// - read select resets to one, asynchronous, on reset or power-down; here power-down clears it synchronously, after the pin synchronisers.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "flash_burst_consts.vh"

module sync_burst_read_port (
  // apb clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output reg                  pslverr,
  // flash bus pins from the host controller
  input  wire                 reset_powerdown_n,
  input  wire                 chip_en_n,
  input  wire                 out_en_n,
  input  wire                 write_en_n,
  input  wire                 latch_en_n,
  input  wire                 burst_adv_n,
  input  wire                 ref_clk,
  input  wire [`ADDR_W-1:0]   addr_in,
  // flash bus pins toward the host controller
  output wire [`DATA_W-1:0]   data_out,
  output wire                 data_oe,
  output wire                 data_ready
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LAT  = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // initial latency code to cycle count, undefined codes fall back to 8
  function [3:0] xlat_cycles;
    input [3:0] code;
    begin
      case (code)
        4'b0010: xlat_cycles = 4'd7;
        4'b0011: xlat_cycles = 4'd8;
        4'b0100: xlat_cycles = 4'd9;
        4'b0101: xlat_cycles = 4'd10;
        4'b0110: xlat_cycles = 4'd11;
        4'b1001: xlat_cycles = 4'd12;
        4'b1010: xlat_cycles = 4'd13;
        4'b1011: xlat_cycles = 4'd13;
        4'b1101: xlat_cycles = 4'd15;
        default: xlat_cycles = 4'd8;
      endcase
    end
  endfunction

  // length code to wrap mask, unknown codes behave as length 4
  function [`ADDR_W-1:0] len_mask;
    input [2:0] code;
    begin
      case (code)
        `LEN_8:    len_mask = 8'h07;
        `LEN_CONT: len_mask = 8'hFF;
        default:   len_mask = 8'h03;
      endcase
    end
  endfunction

  // word address for an offset into the burst
  function [`ADDR_W-1:0] burst_addr;
    input [`ADDR_W-1:0] start;
    input [`ADDR_W-1:0] offs;
    input [2:0]         len;
    input               seq;
    reg   [`ADDR_W-1:0] m;
    begin
      m = len_mask(len);
      if (len == `LEN_CONT || seq) begin
        burst_addr = (start & ~m) | ((start + offs) & m);
      end else begin
        burst_addr = (start & ~m) | ((start ^ offs) & m);
      end
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [6:0]          pin_meta_reg;
  reg [6:0]          pin_sync_reg;
  reg                clk_prev_reg;
  reg                le_prev_reg;
  reg [`ADDR_W-1:0]  addr_meta_reg;
  reg [`ADDR_W-1:0]  addr_sync_reg;

  // every pin is asynchronous to pclk, two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg  <= 7'h7F;
      pin_sync_reg  <= 7'h7F;
      clk_prev_reg  <= 1'b0;
      le_prev_reg   <= 1'b1;
      addr_meta_reg <= {`ADDR_W{1'b0}};
      addr_sync_reg <= {`ADDR_W{1'b0}};
    end else begin
      pin_meta_reg  <= {reset_powerdown_n, chip_en_n, out_en_n, write_en_n,
                        latch_en_n, burst_adv_n, ref_clk};
      pin_sync_reg  <= pin_meta_reg;
      clk_prev_reg  <= pin_sync_reg[0];
      le_prev_reg   <= pin_sync_reg[2];
      addr_meta_reg <= addr_in;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  wire rp_s  = pin_sync_reg[6];
  wire ce_s  = pin_sync_reg[5];
  wire oe_s  = pin_sync_reg[4];
  wire we_s  = pin_sync_reg[3];
  wire le_s  = pin_sync_reg[2];
  wire adv_s = pin_sync_reg[1];
  wire clk_s = pin_sync_reg[0];

  // ****************************************************************
  // configuration and apb slave
  // ****************************************************************
  reg [15:0]         cfg_reg;
  reg                ctrl_slow_reg;
  reg [`ADDR_W-1:0]  load_addr_reg;
  wire               apb_setup = psel & ~penable;
  wire               apb_write = psel & penable & pwrite;
  wire               mapped    = (paddr == `REG_CONFIG) || (paddr == `REG_STATUS) ||
                                 (paddr == `REG_MEM_ADDR) || (paddr == `REG_MEM_DATA) ||
                                 (paddr == `REG_CTRL);
  wire               mem_wr    = apb_write && (paddr == `REG_MEM_DATA);

  assign pready = 1'b1; // every access finishes in its first access cycle

  // power-down clears the configuration as a reset does
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg       <= `CFG_RESET;
      ctrl_slow_reg <= `CTRL_RESET;
      load_addr_reg <= {`ADDR_W{1'b0}};
    end else if (!rp_s) begin
      cfg_reg       <= `CFG_RESET;
      ctrl_slow_reg <= `CTRL_RESET;
    end else if (apb_write) begin
      case (paddr)
        `REG_CONFIG:   cfg_reg       <= pwdata[15:0];
        `REG_CTRL:     ctrl_slow_reg <= pwdata[`CTRL_SLOW];
        `REG_MEM_ADDR: load_addr_reg <= pwdata[`ADDR_W-1:0];
        `REG_MEM_DATA: load_addr_reg <= load_addr_reg + 8'h01; // auto increment
        default:       load_addr_reg <= load_addr_reg;
      endcase
    end
  end

  wire               sync_mode = ~cfg_reg[`CFG_READ_SEL];
  wire [3:0]         xcode     = cfg_reg[`CFG_XLAT_HI:`CFG_XLAT_LO];
  wire [2:0]         len_code  = cfg_reg[`CFG_LEN_HI:`CFG_LEN_LO];
  wire               cont      = (len_code == `LEN_CONT);
  // latency codes 1011 (13 cycles) and 1101 (15 cycles) force a two-cycle word period
  wire               ylat_two  = cfg_reg[`CFG_YLAT] || (xcode == 4'b1011) ||
                                 (xcode == 4'b1101);

  // ****************************************************************
  // active edge and burst state
  // ****************************************************************
  reg [1:0]          state_reg;
  reg [3:0]          lat_cnt_reg;
  reg                yph_reg;
  reg [`ADDR_W-1:0]  start_reg;
  reg [`ADDR_W-1:0]  offs_reg;
  reg                odd_reg;
  reg                le_taken_reg;
  reg                unaligned_reg;
  reg                crossed_reg;
  reg                wait_reg;

  // edge select on the synchronised reference clock
  wire k_edge = cfg_reg[`CFG_EDGE] ? (clk_s & ~clk_prev_reg)
                                   : (~clk_s & clk_prev_reg);
  wire bus_ok = sync_mode & ~ce_s & rp_s;
  wire le_rise = le_s & ~le_prev_reg;
  // capture at the first active edge with latch low, else at latch release
  wire capture = bus_ok & we_s & ~le_taken_reg &
                 ((k_edge & ~le_s) | le_rise);
  wire [`ADDR_W-1:0] cur_addr = burst_addr(start_reg, offs_reg, len_code,
                                           cfg_reg[`CFG_ORDER]);
  // slow clock with two-cycle words drops advance samples on odd cycles
  wire adv_ok = ~adv_s & ~(ctrl_slow_reg & ylat_two & odd_reg);
  wire word_end = ~ylat_two | yph_reg;
  wire [`ADDR_W-1:0] next_addr = burst_addr(start_reg, offs_reg + 8'h01, len_code,
                                            cfg_reg[`CFG_ORDER]);

  // burst sequencer, loaded at capture, stepped on active reference clock edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_IDLE;
      lat_cnt_reg   <= 4'h0;
      yph_reg       <= 1'b0;
      start_reg     <= {`ADDR_W{1'b0}};
      offs_reg      <= {`ADDR_W{1'b0}};
      odd_reg       <= 1'b0;
      le_taken_reg  <= 1'b0;
      unaligned_reg <= 1'b0;
      crossed_reg   <= 1'b0;
      wait_reg      <= 1'b0;
    end else if (!bus_ok) begin
      state_reg    <= ST_IDLE;
      le_taken_reg <= 1'b0;
      wait_reg     <= 1'b0;
    end else begin
      if (le_s) begin
        le_taken_reg <= 1'b0;
      end
      if (capture) begin
        // a new latch mid-burst restarts the latency, so invalid words appear
        start_reg     <= addr_sync_reg;
        offs_reg      <= {`ADDR_W{1'b0}};
        lat_cnt_reg   <= xlat_cycles(xcode) - 4'd1;
        state_reg     <= ST_LAT;
        le_taken_reg  <= 1'b1;
        yph_reg       <= 1'b0;
        odd_reg       <= 1'b0;
        wait_reg      <= 1'b0;
        crossed_reg   <= 1'b0;
        unaligned_reg <= (addr_sync_reg[1:0] != 2'b00);
      end else if (k_edge) begin
        case (state_reg)
          ST_LAT: begin
            if (lat_cnt_reg <= 4'd1) begin
              state_reg <= ST_DATA;
            end
            lat_cnt_reg <= lat_cnt_reg - 4'd1;
          end
          ST_DATA: begin
            odd_reg <= ~odd_reg;
            if (wait_reg) begin
              wait_reg <= 1'b0;
            end else if (word_end) begin
              yph_reg <= 1'b0;
              if (adv_ok) begin
                offs_reg <= offs_reg + 8'h01;
                // one extra wait when an unaligned continuous run hits a page
                if (cont && unaligned_reg && !crossed_reg &&
                    next_addr[1:0] == 2'b00) begin
                  wait_reg    <= 1'b1;
                  crossed_reg <= 1'b1;
                end
              end
            end else if (!adv_s) begin
              yph_reg <= 1'b1;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // data, enable and ready outputs
  // ****************************************************************
  reg        data_oe_reg;
  reg        ready_reg;
  wire       invalid_now = (state_reg == ST_LAT) | wait_reg;
  // early warning: the word before the page crossing of an unaligned run
  wire       invalid_soon = (state_reg == ST_LAT && lat_cnt_reg > 4'd1) |
                            (cont & unaligned_reg & ~crossed_reg &
                             (state_reg == ST_DATA) & (cur_addr[1:0] == 2'b11));

  // pins follow the synchronised enables; output enable high releases them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_reg <= 1'b0;
      ready_reg   <= 1'b1;
    end else begin
      data_oe_reg <= bus_ok & ~oe_s & (state_reg != ST_IDLE);
      ready_reg   <= cfg_reg[`CFG_RDY_TIME] ? ~(invalid_now | invalid_soon)
                                            : ~invalid_now;
    end
  end

  burst_word_mem u_mem (
    .pclk    (pclk),
    .wr_en   (mem_wr),
    .wr_addr (load_addr_reg),
    .wr_data (pwdata[`DATA_W-1:0]),
    .rd_addr (cur_addr),
    .rd_data (data_out)
  );

  assign data_oe    = data_oe_reg;
  assign data_ready = ready_reg;

  // read data latched in the setup cycle, so the access phase needs no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= ~mapped;
      case (paddr)
        `REG_CONFIG:   prdata <= {16'h0000, cfg_reg};
        `REG_STATUS:   prdata <= {8'h00, cur_addr, offs_reg, 1'b0, wait_reg, ready_reg,
                                  data_oe_reg, 2'b00, state_reg};
        `REG_MEM_ADDR: prdata <= {24'h00_0000, load_addr_reg};
        `REG_CTRL:     prdata <= {31'h0000_0000, ctrl_slow_reg};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // sync_burst_read_port

`default_nettype wire

// >>> verif/burst_port_monitor.sv
// checker for the burst read port pins and its apb slave
`timescale 1ns/1ns
`default_nettype none
`include "flash_burst_consts.vh"

module burst_port_monitor (
  // apb slave
  input wire               pclk, presetn, psel, penable, pwrite,
  input wire [7:0]         paddr,
  input wire [31:0]        pwdata, prdata,
  input wire               pready, pslverr,
  // flash pins
  input wire               reset_powerdown_n, chip_en_n, out_en_n, write_en_n,
  input wire               latch_en_n, burst_adv_n, ref_clk, data_oe, data_ready,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [`DATA_W-1:0] data_out
);
  // ****
  // decode and sequences
  // ****
  // five word registers from offset zero
  wire mapped = paddr[1:0] == 2'h0 && paddr <= `REG_CTRL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pins cross two sync flops and a register, so allow four cycles for the enables, eight for advance held
  sequence ce_off; chip_en_n [*4]; endsequence
  sequence oe_off; out_en_n [*4]; endsequence
  sequence adv_held; (!chip_en_n && burst_adv_n) [*8]; endsequence
  // ****
  // properties
  // ****
  chk_standby_release: assert property (ce_off |-> !data_oe)
    else $error("data pins driven while deselected");
  chk_output_gate: assert property (oe_off |-> !data_oe)
    else $error("data pins driven with output enable high");
  chk_powerdown_idle: assert property ((!reset_powerdown_n) [*4] |-> !data_oe)
    else $error("data pins driven in power-down");
  chk_suspend_freeze: assert property (adv_held |-> $stable(data_out))
    else $error("burst word moved while advance held high");
  chk_reset_idle: assert property ($rose(presetn) |-> !data_oe && data_ready && !pslverr)
    else $error("outputs not idle after reset");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_apb_refuse: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not match address map");
  chk_refused_zero: assert property (psel && penable && !pwrite && !mapped |->
                                     prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
endmodule // burst_port_monitor

bind sync_burst_read_port burst_port_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reset_powerdown_n(reset_powerdown_n), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
  .write_en_n(write_en_n), .latch_en_n(latch_en_n), .burst_adv_n(burst_adv_n),
  .ref_clk(ref_clk), .data_oe(data_oe), .data_ready(data_ready), .addr_in(addr_in),
  .data_out(data_out));
`default_nettype wire

// >>> verif/burst_host.sv
// host controller model for the flash burst pins
`timescale 1ns/1ns
`default_nettype none
`include "flash_burst_consts.vh"

module burst_host (
  // clock
  input wire                 pclk,
  // pins toward the device
  output logic               chip_en_n, out_en_n, write_en_n,
  output logic               latch_en_n, burst_adv_n, ref_clk,
  output logic [`ADDR_W-1:0] addr_in,
  // pins from the device
  input wire [`DATA_W-1:0]   data_out,
  input wire                 data_oe, data_ready
);
  logic [`DATA_W-1:0] got[$];  // valid words in order
  int                 lows;    // ready low before the first word
  int                 gaps;    // ready low after it
  // ****
  // idle bus
  // ****
  // deselected, clock parked low outside frames
  initial begin
    {chip_en_n, out_en_n, write_en_n, latch_en_n, burst_adv_n} = 5'h1f;
    ref_clk = 1'b0;
    addr_in = 8'h00;
  end
  // ****
  // one frame of n reference clock cycles
  // ****
  // controls settle before either edge; words read late since pins are synced
  task automatic frame(input logic [`ADDR_W-1:0] a, input int n, s0, s1, ab);
    got.delete();
    lows = 0;
    gaps = 0;
    for (int k = 0; k < n; k++) begin
      chip_en_n   <= k >= ab;
      write_en_n  <= 1'b1;
      latch_en_n  <= k != 0;
      addr_in     <= k == 0 ? a : ~a;   // released address shows junk
      out_en_n    <= k >= s0 && k < s1;
      burst_adv_n <= k >= s0 && k < s1;
      repeat (4) @(posedge pclk);
      ref_clk <= 1'b1;
      repeat (6) @(posedge pclk);
      ref_clk <= 1'b0;
      repeat (9) @(posedge pclk);
      @(negedge pclk);
      if (data_oe === 1'b1 && data_ready === 1'b1) got.push_back(data_out);
      else if (data_ready === 1'b0 && got.size() == 0) lows++;
      else if (data_ready === 1'b0) gaps++;
      @(posedge pclk);
    end
    {chip_en_n, out_en_n, latch_en_n, burst_adv_n} <= 4'hf;
    @(posedge pclk);
  endtask
endmodule // burst_host
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the synchronous burst read port
`timescale 1ns/1ns
`default_nettype none
`include "flash_burst_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end

module tb;
  // ****
  // signals and instances
  // ****
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic               reset_powerdown_n = 1'b1;
  wire  [31:0]        prdata;
  wire                pready, pslverr, data_oe, data_ready, ref_clk;
  wire                chip_en_n, out_en_n, write_en_n, latch_en_n, burst_adv_n;
  wire  [`ADDR_W-1:0] addr_in;
  wire  [`DATA_W-1:0] data_out;
  int                 error_cnt = 0;
  int                 checks = 0;
  // 100 MHz apb clock
  always #5 pclk = ~pclk;
  sync_burst_read_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_powerdown_n(reset_powerdown_n), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .latch_en_n(latch_en_n), .burst_adv_n(burst_adv_n),
    .ref_clk(ref_clk), .addr_in(addr_in), .data_out(data_out), .data_oe(data_oe),
    .data_ready(data_ready));
  burst_host host (.pclk(pclk), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .latch_en_n(latch_en_n), .burst_adv_n(burst_adv_n),
    .ref_clk(ref_clk), .addr_in(addr_in), .data_out(data_out), .data_oe(data_oe),
    .data_ready(data_ready));
  // ****
  // apb master and burst check
  // ****
  // one transfer held until pready, then an idle cycle so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask
  // array pattern, distinct in both bytes
  function automatic logic [`DATA_W-1:0] wv(input logic [7:0] i);
    return {i ^ 8'h5a, i};
  endfunction
  // program the config, run a frame, compare latency, count and word order
  task automatic burst(input logic [15:0] c, input logic [7:0] a,
                       input int n, s0, s1, ab, lo, hi, gp);
    logic [7:0] x;
    wr(`REG_CONFIG, {16'h0000, c});
    host.frame(a, n, s0, s1, ab);
    `CHK(host.lows inside {7, 8}, 1'b1)
    `CHK(host.got.size() inside {[lo:hi]}, 1'b1)
    if (gp >= 0) `CHK(host.gaps, gp)
    foreach (host.got[i]) begin
      x = c[9] ? i[8:1] : i[7:0];
      if (c[2:0] == `LEN_CONT) x = a + x;
      else if (c[2:0] == `LEN_8) x = c[7] ? {a[7:3], a[2:0] + x[2:0]} : a ^ {5'h00, x[2:0]};
      else x = c[7] ? {a[7:2], a[1:0] + x[1:0]} : a ^ {6'h00, x[1:0]};
      `CHK(host.got[i], wv(x))
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // tests
  // ****
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`REG_CONFIG, 32'h0000_8000, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    wr(`REG_MEM_ADDR, 32'h0000_0000);
    for (int i = 0; i < `MEM_DEPTH; i++) wr(`REG_MEM_DATA, {16'h0000, wv(i[7:0])});
    host.frame(8'h10, 12, 99, 99, 99);
    `CHK(host.lows, 0)
    burst(16'h18c1, 8'h12, 16, 99, 99, 99, 7, 10, -1);
    burst(16'h1841, 8'h13, 12, 99, 99, 99, 3, 6, -1);
    burst(16'h1882, 8'h25, 16, 99, 99, 99, 7, 10, -1);
    burst(16'h18c2, 8'h20, 22, 10, 13, 99, 10, 13, -1);
    burst(16'h18c2, 8'h30, 16, 99, 99, 10, 1, 3, -1);
    burst(16'h18c7, 8'hfe, 16, 99, 99, 99, 6, 9, 1);
    burst(16'h18c7, 8'h40, 14, 99, 99, 99, 5, 8, 0);
    burst(16'h1ac1, 8'h08, 20, 99, 99, 99, 10, 14, -1);
    reset_powerdown_n <= 1'b0;
    repeat (10) @(posedge pclk);
    reset_powerdown_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`REG_CONFIG, 32'h0000_8000, 1'b0);
    summarize;
  end
  // watchdog against a hung wait
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] %0t timeout", $time);
    summarize;
  end
endmodule // tb
`default_nettype wire
